// ==== src/pulsar_gate_lookup.sv ====
`include "pgl_map.svh"
module pulsar_gate_lookup
    import pgl_pkg::*;
(
    input  wire logic         clk,          // 100 MHz clock
    input  wire logic         rst,          // sync reset, high
    input  wire logic         cycle_sync,   // sequencer cycle sync pulse
    input  wire logic         point_step,   // one pulse per spectral point
    input  wire logic         phase_load,   // phase store to register
    input  wire logic         phase_sdata,  // serial phase bit, lsb first
    input  wire logic         phase_sclk_en,// shift enable for phase store
    input  wire logic         cpu_mode,     // processor owns the table
    input  wire pgl_phase_t   cpu_page_wr,  // page value
    input  wire logic         cpu_page_we,  // page write strobe
    input  wire pgl_point_t   cpu_addr,     // entry within page
    input  wire pgl_word_t    cpu_wdata,    // entry to write
    input  wire logic         cpu_we,       // entry write strobe
    input  wire logic         cpu_re,       // entry read request
    output pgl_word_t         cpu_rdata,    // read entry
    output logic              cpu_rvalid,   // read data pulse
    output pgl_phase_t        cpu_page,     // page register readback
    output pgl_word_t         gate_a,       // gates for cards 0..4
    output pgl_word_t         gate_b,       // gates for cards 5..9
    output pgl_word_t         gate_mon      // gates for rack monitor card
);
    // -------------------------------------------------------------
    // address sources
    // -------------------------------------------------------------
    pgl_point_t point;
    pgl_phase_t phase_store;
    pgl_phase_t phase;
    pgl_cpu_e   cpu_state;
    pgl_word_t  ram_q;
    logic       gate_ok;

    function automatic pgl_addr_t make_addr(input pgl_phase_t hi, input pgl_point_t lo);
        make_addr = {hi, lo};
    endfunction

    wire pgl_addr_t gate_addr = make_addr(phase, point);
    wire pgl_addr_t cpu_full  = make_addr(cpu_page, cpu_addr);
    wire pgl_addr_t ram_addr  = cpu_mode ? cpu_full : gate_addr;
    wire logic      ram_we    = cpu_mode & cpu_we;
    wire pgl_point_t next_point = cycle_sync ? `PGL_POINT_RST : point + 8'h01;

    // -------------------------------------------------------------
    // counter and phase
    // -------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            point <= `PGL_POINT_RST;
        end else if (cycle_sync || point_step) begin
            point <= next_point;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            phase_store <= `PGL_PHASE_RST;
        end else if (phase_sclk_en) begin
            phase_store <= {phase_sdata, phase_store[`PGL_PHASE_W-1:1]};
        end
    end

    // one phase per cycle: taken at the cycle sync or explicit load
    always_ff @(posedge clk) begin
        if (rst) begin
            phase <= `PGL_PHASE_RST;
        end else if (phase_load || cycle_sync) begin
            phase <= phase_store;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_page <= `PGL_PAGE_RST;
        end else if (cpu_page_we) begin
            cpu_page <= cpu_page_wr;
        end
    end

    pgl_table_ram u_ram (
        .clk   (clk),
        .we    (ram_we),
        .addr  (ram_addr),
        .wdata (cpu_wdata),   // one nibble per entry
        .rdata (ram_q)
    );

    // -------------------------------------------------------------
    // processor read: ram is registered, so data lands one cycle later
    // -------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_state  <= PGL_IDLE;
            cpu_rvalid <= 1'b0;
            cpu_rdata  <= `PGL_RDATA_RST;
        end else begin
            cpu_rvalid <= 1'b0;
            case (cpu_state)
                PGL_IDLE: if (cpu_mode && cpu_re) cpu_state <= PGL_READ;
                PGL_READ: begin
                    cpu_rdata  <= ram_q;
                    cpu_rvalid <= 1'b1;
                    cpu_state  <= PGL_IDLE;
                end
                default: cpu_state <= PGL_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------
    // gate outputs
    // -------------------------------------------------------------
    // gate_ok lags one cycle to match the ram latency
    always_ff @(posedge clk) begin
        if (rst) begin
            gate_ok <= 1'b0;
        end else begin
            gate_ok <= ~cpu_mode;
        end
    end

    // single ram port: processor access and gating cannot share a cycle,
    // so the gates sit at off rather than show a processor entry
    wire pgl_word_t gate_word = (gate_ok && !cpu_mode) ? ram_q : `PGL_GATE_OFF;

    // bit n to pipeline n; card decides whether to use them
    always_ff @(posedge clk) begin
        if (rst) begin
            gate_a   <= `PGL_GATE_OFF;
            gate_b   <= `PGL_GATE_OFF;
            gate_mon <= `PGL_GATE_OFF;
        end else begin
            gate_a   <= gate_word;
            gate_b   <= gate_word;
            gate_mon <= gate_word;
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    copies_equal_a: assert property (@(posedge clk) disable iff (rst)
        gate_a == gate_b && gate_a == gate_mon) else $error("gate copies differ");

    cpu_gates_off_a: assert property (@(posedge clk) disable iff (rst)
        cpu_mode |=> gate_a == `PGL_GATE_OFF) else $error("gates not off in cpu mode");

    point_sync_a: assert property (@(posedge clk) disable iff (rst)
        cycle_sync |=> point == 8'h00) else $error("point not realigned");

    point_step_a: assert property (@(posedge clk) disable iff (rst)
        (point_step && !cycle_sync) |=> point == $past(point) + 8'h01)
        else $error("point did not step");

    phase_take_a: assert property (@(posedge clk) disable iff (rst)
        (phase_load && !phase_sclk_en) |=> phase == $past(phase_store))
        else $error("phase not loaded");

    page_addr_a: assert property (@(posedge clk) disable iff (rst)
        cpu_mode |-> ram_addr[17:8] == cpu_page) else $error("page not used");

    gate_addr_a: assert property (@(posedge clk) disable iff (rst)
        !cpu_mode |-> ram_addr == {phase, point}) else $error("gate address wrong");

    read_resp_a: assert property (@(posedge clk) disable iff (rst)
        (cpu_state == PGL_IDLE && cpu_mode && cpu_re) |=> ##1 cpu_rvalid)
        else $error("read not answered");

    no_write_gate_a: assert property (@(posedge clk) disable iff (rst)
        !cpu_mode |-> !ram_we) else $error("write while gating");

    // -------------------------------------------------------------
    // holding and timing checks
    // -------------------------------------------------------------
    // a stale word after leaving processor mode would gate the wrong points
    leave_cpu_off_a: assert property (@(posedge clk) disable iff (rst)
        $fell(cpu_mode) |=> gate_a == `PGL_GATE_OFF)
        else $error("gates not off after cpu mode");

    gate_follow_a: assert property (@(posedge clk) disable iff (rst)
        (gate_ok && !cpu_mode) |=> gate_a == $past(ram_q))
        else $error("gate word not passed through");

    gate_ok_lag_a: assert property (@(posedge clk) disable iff (rst)
        gate_ok |-> !$past(cpu_mode))
        else $error("gate enable ahead of cpu mode");

    mon_off_cpu_a: assert property (@(posedge clk) disable iff (rst)
        cpu_mode |=> gate_mon == `PGL_GATE_OFF)
        else $error("monitor gates not off in cpu mode");

    point_hold_a: assert property (@(posedge clk) disable iff (rst)
        !(point_step || cycle_sync) |=> $stable(point))
        else $error("point moved without step");

    phase_hold_a: assert property (@(posedge clk) disable iff (rst)
        !(phase_load || cycle_sync) |=> $stable(phase))
        else $error("phase moved inside a cycle");

    phase_shift_a: assert property (@(posedge clk) disable iff (rst)
        phase_sclk_en |=> phase_store[9] == $past(phase_sdata))
        else $error("serial phase bit not taken");

    store_hold_a: assert property (@(posedge clk) disable iff (rst)
        !phase_sclk_en |=> $stable(phase_store))
        else $error("phase store moved without shift");

    page_write_a: assert property (@(posedge clk) disable iff (rst)
        cpu_page_we |=> cpu_page == $past(cpu_page_wr))
        else $error("page not written");

    page_hold_a: assert property (@(posedge clk) disable iff (rst)
        !cpu_page_we |=> $stable(cpu_page))
        else $error("page moved without write");

    rvalid_pulse_a: assert property (@(posedge clk) disable iff (rst)
        cpu_rvalid |=> !cpu_rvalid)
        else $error("read valid longer than one cycle");

    read_data_a: assert property (@(posedge clk) disable iff (rst)
        cpu_rvalid |-> cpu_rdata == $past(ram_q))
        else $error("read data not from table");

    rdata_hold_a: assert property (@(posedge clk) disable iff (rst)
        !cpu_rvalid |-> $stable(cpu_rdata))
        else $error("read data moved without valid");

    read_refused_a: assert property (@(posedge clk) disable iff (rst)
        (cpu_state == PGL_IDLE && !cpu_mode) |=> !cpu_rvalid ##1 !cpu_rvalid)
        else $error("read answered while gating");
endmodule // pulsar_gate_lookup

// ==== src/pgl_map.svh ====
`ifndef PGL_MAP_SVH
`define PGL_MAP_SVH
`define PGL_POINT_W      8
`define PGL_PHASE_W      10
`define PGL_ADDR_W       18
`define PGL_WORD_W       4
`define PGL_DEPTH        262144
`define PGL_GATE_OFF     4'hF
`define PGL_POINT_RST    8'h00
`define PGL_PHASE_RST    10'h000
`define PGL_PAGE_RST     10'h000
`define PGL_RDATA_RST    4'h0
`define PGL_BYTE_ADDR_W  17
`endif

// ==== src/pgl_pkg.sv ====
`include "pgl_map.svh"
package pgl_pkg;
    typedef logic [`PGL_ADDR_W-1:0]  pgl_addr_t;
    typedef logic [`PGL_WORD_W-1:0]  pgl_word_t;
    typedef logic [`PGL_PHASE_W-1:0] pgl_phase_t;
    typedef logic [`PGL_POINT_W-1:0] pgl_point_t;
    typedef enum logic [1:0] {PGL_IDLE, PGL_READ, PGL_DONE} pgl_cpu_e;
endpackage

// ==== src/pgl_table_ram.sv ====
`include "pgl_map.svh"
module pgl_table_ram
    import pgl_pkg::*;
(
    input  wire logic      clk,   // system clock
    input  wire logic      we,    // write strobe
    input  wire pgl_addr_t addr,  // entry address
    input  wire pgl_word_t wdata, // write entry
    output pgl_word_t      rdata  // registered read entry
);
    pgl_word_t mem [0:`PGL_DEPTH-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule // pgl_table_ram

// ==== tb/pgl_card_model.sv ====
module pgl_card_model
    import pgl_pkg::*;
(
    input  wire logic      clk,     // system clock
    input  wire logic      card_en, // card control word gating bit
    input  wire pgl_word_t gate,    // shared gate lines
    output pgl_word_t      pipe_on  // pipelines taking data
);
    timeunit 1ns;
    timeprecision 100ps;
    // a low gate bit lets its own pipeline through, only if the card opts in
    always_ff @(posedge clk) pipe_on <= card_en ? ~gate : 4'h0;
endmodule // pgl_card_model

// ==== tb/pulsar_gate_lookup_bench.sv ====
`include "pgl_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module pulsar_gate_lookup_bench
    import pgl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        clk = 0, rst = 1, cycle_sync, point_step, phase_load, phase_sdata;
    logic        phase_sclk_en, cpu_mode, cpu_page_we, cpu_we, cpu_re, cpu_rvalid, card_en;
    pgl_phase_t  cpu_page_wr, cpu_page, page;
    pgl_point_t  cpu_addr;
    pgl_word_t   cpu_wdata, cpu_rdata, gate_a, gate_b, gate_mon, pipe_on;
    pgl_word_t   ref_w [256];
    logic [31:0] seed = 32'h00018254, r;
    int          err_count = 0, n_checks = 0, i, p;
    pulsar_gate_lookup dut (.clk, .rst, .cycle_sync, .point_step, .phase_load, .phase_sdata,
        .phase_sclk_en, .cpu_mode, .cpu_page_wr, .cpu_page_we, .cpu_addr, .cpu_wdata, .cpu_we,
        .cpu_re, .cpu_rdata, .cpu_rvalid, .cpu_page, .gate_a, .gate_b, .gate_mon);
    pgl_card_model card (.clk, .card_en, .gate(gate_a), .pipe_on);
    initial forever #5 clk = ~clk;
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        complete_run();
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic pgl_word_t exp_on(logic en, pgl_word_t g);
        return en ? ~g : 4'h0;
    endfunction
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task wr(pgl_point_t a, pgl_word_t d);
        @(posedge clk);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_we <= 1'b1;
        @(posedge clk);
        cpu_we <= 1'b0;
    endtask
    // low nibble of each host byte lands at the even entry
    task wr_byte(pgl_point_t a, logic [7:0] b);
        wr(a, b[3:0]);
        wr(a + 8'h01, b[7:4]);
        ref_w[a] = b[3:0];
        ref_w[a + 8'h01] = b[7:4];
    endtask
    task rd_chk(pgl_point_t a);
        int k;
        @(posedge clk);
        cpu_addr <= a;
        cpu_re <= 1'b1;
        @(posedge clk);
        cpu_re <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (cpu_rvalid !== 1'b1 && k < 8);
        if (cpu_rvalid !== 1'b1) begin
            err_count++;
            complete_run();
        end else begin
            `CHK(cpu_rdata, ref_w[a])
        end
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        {cycle_sync, point_step, phase_load, phase_sdata, phase_sclk_en} = '0;
        {cpu_mode, cpu_page_we, cpu_we, cpu_re, card_en} = '0;
        {cpu_page_wr, cpu_addr, cpu_wdata} = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK(gate_a, `PGL_GATE_OFF)
        `CHK(cpu_page, `PGL_PAGE_RST)
        for (p = 0; p < 2; p++) begin
            r = xs();
            page = p ? r[9:0] : 10'h3FF;
            @(posedge clk);
            cpu_mode <= 1'b1;
            cpu_page_wr <= page;
            cpu_page_we <= 1'b1;
            @(posedge clk);
            cpu_page_we <= 1'b0;
            for (i = 0; i < 256; i += 2) begin
                r = xs();
                wr_byte(pgl_point_t'(i), r[7:0]);
            end
            #1;
            `CHK(cpu_page, page)
            `CHK(gate_b, `PGL_GATE_OFF)
            rd_chk(8'h00);
            rd_chk(8'hFF);
            rd_chk(r[15:8]);
            // phase shifts in lsb first while the processor still owns the table
            for (i = 0; i < 10; i++) begin
                @(posedge clk);
                phase_sdata <= page[i];
                phase_sclk_en <= 1'b1;
            end
            @(posedge clk);
            phase_sclk_en <= 1'b0;
            phase_load <= 1'b1;
            @(posedge clk);
            phase_load <= 1'b0;
            cpu_mode <= 1'b0;
            cycle_sync <= 1'b1;
            // first page opts in, second opts out, so both card cases are seen
            card_en <= (p == 0);
            @(posedge clk);
            cycle_sync <= 1'b0;
            // one extra step past 255 shows the counter wrapping
            for (i = 0; i <= 257; i++) begin
                if (i == 257) cycle_sync <= 1'b1;
                repeat (4) @(posedge clk);
                cycle_sync <= 1'b0;
                repeat (3) @(posedge clk);
                #1;
                `CHK(gate_a, ref_w[i == 257 ? 0 : i % 256])
                `CHK(gate_b, gate_a)
                `CHK(gate_mon, gate_a)
                `CHK(pipe_on, exp_on(card_en, ref_w[i == 257 ? 0 : i % 256]))
                @(posedge clk);
                // step past the wrap too, so the final sync realigns from point 1
                point_step <= (i < 257);
                @(posedge clk);
                point_step <= 1'b0;
            end
            $display("test page %h done", page);
        end
        complete_run();
    end
endmodule // pulsar_gate_lookup_bench
